/* File: tx_drive_pkg.sv */
// shared constants and the rail carrier type for the transmit drive stage
package tx_drive_pkg;
	localparam int NUM_CH      = 3;
	localparam int CNT_W       = 8;
	localparam int FAULT_LIMIT = 128;
	localparam int FIFO_DEPTH  = 8;
	localparam int ADDR_W      = 8;

	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

	// control fields
	localparam int CTRL_TX_ON_LSB = 0;
	localparam int CTRL_INTMON    = 3;
	localparam int CTRL_EDGE      = 4;
	localparam logic [NUM_CH-1:0] RST_TX_ON = 3'h0;
	localparam logic RST_INTMON = 1'h0;
	localparam logic RST_EDGE   = 1'h1;

	// status fields
	localparam int STAT_FAULT_LSB = 0;
	localparam int STAT_TX_ON_LSB = 3;
	localparam int STAT_HOST      = 6;
	localparam int STAT_FULL_LSB  = 8;

	typedef struct packed {
		logic pos;
		logic neg;
	} rail_t;
endpackage

/* File: rail_fifo.sv */
// small synchronous fifo holding sampled rail symbols
`timescale 1ns/1ps
module rail_fifo #(
	parameter int W     = 2,
	parameter int DEPTH = 8
) (
	// clock, reset and clock enable
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             count;
	} fifo_state_t;

	fifo_state_t st;
	fifo_state_t next_st;
	logic        do_push;
	logic        do_pop;

	assign in_ready  = (st.count != (AW+1)'(DEPTH));
	assign out_valid = (st.count != '0);
	assign out_data  = st.mem[st.rd];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (do_push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
		end
		if (do_pop) begin
			next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_st.count = st.count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule

/* File: tx_output_drive_monitor.sv */
// transmit output stage and drive monitor, three channels, apb control
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tx_output_drive_monitor
	import tx_drive_pkg::*;
#(
	parameter int CH    = tx_drive_pkg::NUM_CH,
	parameter int LIMIT = tx_drive_pkg::FAULT_LIMIT,
	parameter int DEPTH = tx_drive_pkg::FIFO_DEPTH
) (
	// clock, reset, enable
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            ce,
	// apb slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [tx_drive_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// mode pins
	input  wire logic                            host_mode_sel,
	input  wire logic                            tx_clock_edge_select,
	output logic                                 host_serial_clock,
	// framer side, per channel
	input  wire logic [CH-1:0]                   tx_line_clock,
	input  wire logic [CH-1:0]                   tx_pos_rail_in,
	input  wire logic [CH-1:0]                   tx_neg_rail_in,
	output logic      [CH-1:0]                   rail_ready,
	input  wire logic [CH-1:0]                   transmitter_on,
	// line side, per channel
	input  wire logic [CH-1:0]                   monitor_pos_in,
	input  wire logic [CH-1:0]                   monitor_neg_in,
	output logic      [CH-1:0]                   line_out_pos,
	output logic      [CH-1:0]                   line_out_pos_oe,
	output logic      [CH-1:0]                   line_out_neg,
	output logic      [CH-1:0]                   line_out_neg_oe,
	output logic      [CH-1:0]                   drive_fault_flag
);
	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [CH-1:0]            clk_s1;
		logic [CH-1:0]            clk_s2;
		logic [CH-1:0]            clk_d;
		logic [CH-1:0]            rp_s1;
		logic [CH-1:0]            rp_s2;
		logic [CH-1:0]            rn_s1;
		logic [CH-1:0]            rn_s2;
		logic [CH-1:0]            mp_s1;
		logic [CH-1:0]            mp_s2;
		logic [CH-1:0]            mn_s1;
		logic [CH-1:0]            mn_s2;
		logic [CH-1:0]            on_s1;
		logic [CH-1:0]            on_s2;
		logic [CH-1:0]            line_pos;
		logic [CH-1:0]            line_neg;
		logic [CH-1:0]            mon_pd;
		logic [CH-1:0]            mon_nd;
		logic [CH-1:0]            fault;
		logic [CH-1:0][CNT_W-1:0] cnt;
		logic                     edge_s1;
		logic                     edge_s2;
		logic                     mode_s1;
		logic                     mode_s2;
		logic [CH-1:0]            reg_tx_on;
		logic                     reg_intmon;
		logic                     reg_edge;
		logic                     armed;
		logic                     err;
		logic [31:0]              rdata;
	} state_t;

	state_t        st;
	state_t        next_st;
	logic          host;
	logic          edge_eff;
	logic          use_int;
	logic [CH-1:0] tx_on_eff;
	logic [CH-1:0] rise;
	logic [CH-1:0] fall;
	logic [CH-1:0] sample;
	logic [CH-1:0] drain;
	logic [CH-1:0] pop;
	logic [CH-1:0] mon_p;
	logic [CH-1:0] mon_n;
	logic [CH-1:0] pulse;
	logic [CH-1:0] out_valid;
	rail_t         fifo_in  [CH];
	rail_t         fifo_out [CH];

	////////////////////////////////////////////////////////////////////////////////
	// mode and edge decode, every pin taken from second synchroniser stage onward, register fields directly

	assign host     = st.mode_s2;
	assign edge_eff = host ? st.reg_edge : st.edge_s2;
	assign tx_on_eff = host ? st.reg_tx_on : st.on_s2;
	assign use_int  = host & st.reg_intmon;
	assign rise     = st.clk_s2 & ~st.clk_d;
	assign fall     = ~st.clk_s2 & st.clk_d;
	assign sample   = edge_eff ? rise : fall;
	assign drain    = edge_eff ? fall : rise;
	assign pop      = drain & tx_on_eff;

	// the line clock is oversampled, so it must stay below a quarter of pclk
	assign mon_p = use_int ? st.line_pos : st.mp_s2;
	assign mon_n = use_int ? st.line_neg : st.mn_s2;
	// per-rail edges so alternating marks are each seen as a pulse
	assign pulse = (mon_p & ~st.mon_pd) | (mon_n & ~st.mon_nd);

	// in hardware mode the pin is an edge selector and the serial clock is idle
	assign host_serial_clock = host & st.edge_s2;

	////////////////////////////////////////////////////////////////////////////////
	// symbol buffers, one per channel

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_ch
			assign fifo_in[g] = '{pos: st.rp_s2[g], neg: st.rn_s2[g]};
			rail_fifo #(
				.W     (2),
				.DEPTH (DEPTH)
			) u_fifo (
				.pclk      (pclk),
				.presetn   (presetn),
				.ce        (ce),
				.in_valid  (sample[g]),
				.in_ready  (rail_ready[g]),
				.in_data   (fifo_in[g]),
				.out_valid (out_valid[g]),
				.out_ready (pop[g]),
				.out_data  (fifo_out[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// apb

	assign pready  = psel & penable & ce & st.armed;
	assign pslverr = pready & st.err;
	assign prdata  = st.rdata;

	function automatic logic [31:0] read_mux(input state_t s, input logic [CH-1:0] on,
			input logic [CH-1:0] rdy, input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = '0;
		if (a == CTRL_OFS) begin
			v[CTRL_TX_ON_LSB +: CH] = s.reg_tx_on;
			v[CTRL_INTMON] = s.reg_intmon;
			v[CTRL_EDGE] = s.reg_edge;
		end else if (a == STAT_OFS) begin
			v[STAT_FAULT_LSB +: CH] = s.fault;
			v[STAT_TX_ON_LSB +: CH] = on;
			v[STAT_HOST] = s.mode_s2;
			v[STAT_FULL_LSB +: CH] = ~rdy;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		next_st.clk_s1  = tx_line_clock;
		next_st.clk_s2  = st.clk_s1;
		next_st.clk_d   = st.clk_s2;
		next_st.rp_s1   = tx_pos_rail_in;
		next_st.rp_s2   = st.rp_s1;
		next_st.rn_s1   = tx_neg_rail_in;
		next_st.rn_s2   = st.rn_s1;
		next_st.mp_s1   = monitor_pos_in;
		next_st.mp_s2   = st.mp_s1;
		next_st.mn_s1   = monitor_neg_in;
		next_st.mn_s2   = st.mn_s1;
		next_st.on_s1   = transmitter_on;
		next_st.on_s2   = st.on_s1;
		next_st.edge_s1 = tx_clock_edge_select;
		next_st.edge_s2 = st.edge_s1;
		next_st.mode_s1 = host_mode_sel;
		next_st.mode_s2 = st.mode_s1;
		next_st.mon_pd  = mon_p;
		next_st.mon_nd  = mon_n;

		for (int i = 0; i < CH; i++) begin
			if (!tx_on_eff[i]) begin
				next_st.line_pos[i] = 1'b0;
				next_st.line_neg[i] = 1'b0;
			end else if (drain[i]) begin
				// both rails high is not a legal symbol and sends a space
				next_st.line_pos[i] = out_valid[i] & fifo_out[i].pos & ~fifo_out[i].neg;
				next_st.line_neg[i] = out_valid[i] & fifo_out[i].neg & ~fifo_out[i].pos;
			end
			if (pulse[i]) begin
				next_st.cnt[i] = '0;
			end else if (rise[i] && st.cnt[i] != CNT_W'(LIMIT)) begin
				next_st.cnt[i] = st.cnt[i] + 1'b1;
			end
			next_st.fault[i] = (next_st.cnt[i] == CNT_W'(LIMIT));
		end

		if (psel && !penable) begin
			next_st.armed = 1'b1;
			next_st.err   = (paddr != CTRL_OFS) && (paddr != STAT_OFS);
			next_st.rdata = read_mux(st, tx_on_eff, rail_ready, paddr);
		end
		if (pready) begin
			next_st.armed = 1'b0;
			if (pwrite && paddr == CTRL_OFS) begin
				next_st.reg_tx_on  = pwdata[CTRL_TX_ON_LSB +: CH];
				next_st.reg_intmon = pwdata[CTRL_INTMON];
				next_st.reg_edge   = pwdata[CTRL_EDGE];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st            <= '0;
			st.reg_tx_on  <= RST_TX_ON;
			st.reg_intmon <= RST_INTMON;
			st.reg_edge   <= RST_EDGE;
		end else if (ce) begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins

	assign line_out_pos     = st.line_pos;
	assign line_out_neg     = st.line_neg;
	assign line_out_pos_oe  = tx_on_eff;
	assign line_out_neg_oe  = tx_on_eff;
	assign drive_fault_flag = st.fault;

	////////////////////////////////////////////////////////////////////////////////
	// checks on channel 0 and on the serial clock

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_fault_rise_cause: assert property ($rose(drive_fault_flag[0]) |->
		$past(st.cnt[0]) == CNT_W'(LIMIT - 1) && $past(rise[0]))
		else $error("fault rose without a full idle count");

	a_fault_after_pulse: assert property (ce && pulse[0] |=>
		!drive_fault_flag[0])
		else $error("fault high right after a pulse");

	a_count_restart: assert property (ce && pulse[0] |=> st.cnt[0] == '0)
		else $error("bit counter did not restart on pulse");

	a_internal_source: assert property (ce && use_int && st.line_pos[0] &&
		!st.mon_pd[0] |=> st.cnt[0] == '0)
		else $error("internal drive pulse not seen by monitor");

	// both directions: a missed sample fails as surely as a wrong-edge one
	a_rise_sample: assert property (!host && st.edge_s2 |->
		sample[0] == (st.clk_s2[0] && !st.clk_d[0]))
		else $error("sample not taken exactly on rising edge");

	a_fall_sample: assert property (!host && !st.edge_s2 |->
		sample[0] == (!st.clk_s2[0] && st.clk_d[0]))
		else $error("sample not taken exactly on falling edge");

	a_host_clock_idle: assert property (!host |-> !host_serial_clock)
		else $error("serial clock active in hardware mode");

	a_pos_pulse_drive: assert property (ce && pop[0] && out_valid[0] &&
		fifo_out[0] == 2'h2 |=> line_out_pos[0] && !line_out_neg[0])
		else $error("positive mark not driven high on pos");

	a_neg_pulse_drive: assert property (ce && pop[0] && out_valid[0] &&
		fifo_out[0] == 2'h1 |=> !line_out_pos[0] && line_out_neg[0])
		else $error("negative mark not driven high on neg");

	a_off_tristate: assert property (ce && !tx_on_eff[0] |=>
		!line_out_pos[0] && !line_out_neg[0])
		else $error("line still driven while transmitter off");

	c_fault_seen:  cover property ($rose(drive_fault_flag[0]));
	c_fault_clear: cover property ($fell(drive_fault_flag[0]));
	c_host_push:   cover property (host && sample[0] && rail_ready[0]);
	c_fifo_full:   cover property (!rail_ready[0]);
endmodule

/* File: tx_framer_model.sv */
// dual-rail framer model: line clock and rail data for every channel
`timescale 1ns/1ps
module tx_framer_model
	import tx_drive_pkg::*;
(
	// clock and control
	input  wire logic                                  pclk,
	input  wire logic                                  run,
	input  wire logic                                  edge_rise,
	input  wire tx_drive_pkg::rail_t [tx_drive_pkg::NUM_CH-1:0] sym,
	// rail pins
	output logic      [tx_drive_pkg::NUM_CH-1:0]       tx_line_clock,
	output logic      [tx_drive_pkg::NUM_CH-1:0]       tx_pos_rail_in,
	output logic      [tx_drive_pkg::NUM_CH-1:0]       tx_neg_rail_in
);
	import tx_drive_pkg::*;
	logic [2:0] ph = 3'h0;
	logic       ok;
	////////////////////////////////////////////////////////////////
	// eight pclk per bit; the clock stands still between frames
	always @(posedge pclk) begin
		if (run) ph <= ph + 3'h1;
	end
	// idles low, the level the edge detector resets to, so reset brings no false edge
	assign tx_line_clock = {NUM_CH{ph[2]}};
	// data valid only two pclk either side of the sampling edge
	// elsewhere the inverse shows, so a wrong-edge sample is seen
	assign ok = run && (edge_rise ? (ph >= 3'h2 && ph < 3'h6) : (ph >= 3'h6 || ph < 3'h2));
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			tx_pos_rail_in[i] = ok ? sym[i].pos : ~sym[i].pos;
			tx_neg_rail_in[i] = ok ? sym[i].neg : ~sym[i].neg;
		end
	end
endmodule

/* File: tb_top.sv */
// self-checking bench for the transmit drive stage
`timescale 1ns/1ps
module tb_top;
	import tx_drive_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        host_mode_sel, tx_clock_edge_select, host_serial_clock, run, samp_rise;
	logic [2:0]  tlc, tpos, tneg, rail_ready, transmitter_on, monitor_pos_in, monitor_neg_in;
	logic [2:0]  line_out_pos, line_out_pos_oe, line_out_neg, line_out_neg_oe, drive_fault_flag;
	rail_t [NUM_CH-1:0] sym;
	int          mismatches, comparisons, cycles;
	////////////////////////////////////////////////////////////////
	tx_output_drive_monitor tx_output_drive_monitor_inst (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_mode_sel(host_mode_sel), .tx_clock_edge_select(tx_clock_edge_select),
		.host_serial_clock(host_serial_clock), .tx_line_clock(tlc), .tx_pos_rail_in(tpos),
		.tx_neg_rail_in(tneg), .rail_ready(rail_ready), .transmitter_on(transmitter_on),
		.monitor_pos_in(monitor_pos_in), .monitor_neg_in(monitor_neg_in),
		.line_out_pos(line_out_pos), .line_out_pos_oe(line_out_pos_oe),
		.line_out_neg(line_out_neg), .line_out_neg_oe(line_out_neg_oe),
		.drive_fault_flag(drive_fault_flag));
	tx_framer_model tx_framer_model_inst (.pclk(pclk), .run(run), .edge_rise(samp_rise),
		.sym(sym), .tx_line_clock(tlc), .tx_pos_rail_in(tpos), .tx_neg_rail_in(tneg));
	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer; waits for pready however long it takes
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] q;
		logic        err;
		apb(1'b0, a, 32'h0, q, err);
		check("prdata", q, e);
		check("pslverr", {31'h0, err}, {31'h0, ee});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        err;
		apb(1'b1, a, d, q, err);
	endtask
	task automatic bits(input int n);
		repeat (n) @(posedge tlc[0]);
		@(posedge pclk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic pulse(input logic [2:0] p, input logic [2:0] n);
		monitor_pos_in <= p;
		monitor_neg_in <= n;
		cyc(4);
		monitor_pos_in <= 3'h0;
		monitor_neg_in <= 3'h0;
		cyc(4);
	endtask
	task automatic line(input logic [2:0] p, input logic [2:0] n);
		check("line_out_pos", line_out_pos, p);
		check("line_out_neg", line_out_neg, n);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// a hang costs a mismatch; the tests need well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, run, samp_rise} = '0;
		{host_mode_sel, transmitter_on, monitor_pos_in, monitor_neg_in} = '0;
		ce = 1'b1;
		tx_clock_edge_select = 1'b1;
		sym = 6'h06;
		cyc(8);
		presetn <= 1'b1;
		cyc(1);
		rd(CTRL_OFS, 32'h10, 1'b0);
		wr(8'h08, 32'h0F);
		rd(CTRL_OFS, 32'h10, 1'b0);
		rd(8'h08, 32'h0, 1'b1);
		check("oe", {line_out_pos_oe, line_out_neg_oe}, 6'h00);
		check("sclk", host_serial_clock, 1'b0);
		// host mode: pin becomes the serial clock, control from the register
		host_mode_sel <= 1'b1;
		cyc(4);
		check("sclk", host_serial_clock, 1'b1);
		tx_clock_edge_select <= 1'b0;
		cyc(4);
		check("sclk", host_serial_clock, 1'b0);
		wr(CTRL_OFS, 32'h0F);
		rd(CTRL_OFS, 32'h0F, 1'b0);
		check("oe", {line_out_pos_oe, line_out_neg_oe}, 6'h3F);
		samp_rise <= 1'b0;
		run <= 1'b1;
		// internal monitor: ch0 toggles, external pin of ch1 toggles but is ignored
		for (int i = 0; i < 40; i++) begin
			sym[0] <= (i % 2) ? 2'b00 : 2'b10;
			monitor_pos_in[1] <= ~monitor_pos_in[1];
			bits(4);
		end
		check("fault", drive_fault_flag, 3'b110);
		rd(STAT_OFS, 32'h7E, 1'b0);
		sym <= 6'h06;
		monitor_pos_in <= 3'h0;
		wr(CTRL_OFS, 32'h08);
		cyc(3);
		check("oe", {line_out_pos_oe, line_out_neg_oe}, 6'h00);
		// hardware mode, rising then falling sampling edge
		host_mode_sel <= 1'b0;
		tx_clock_edge_select <= 1'b1;
		samp_rise <= 1'b1;
		transmitter_on <= 3'h7;
		bits(20);
		line(3'b001, 3'b010);
		check("oe", {line_out_pos_oe, line_out_neg_oe}, 6'h3F);
		tx_clock_edge_select <= 1'b0;
		samp_rise <= 1'b0;
		bits(20);
		line(3'b001, 3'b010);
		// external monitor with the exact limit from the package
		pulse(3'h7, 3'h0);
		bits(FAULT_LIMIT - 4);
		check("fault", drive_fault_flag, 3'b000);
		// ch1 and ch2 gain one period here; two more leave them one short of the limit
		pulse(3'h0, 3'h1);
		bits(2);
		check("fault", drive_fault_flag, 3'b000);
		bits(1);
		check("fault", drive_fault_flag, 3'b110);
		pulse(3'h2, 3'h4);
		check("fault", drive_fault_flag, 3'b000);
		// transmitter off: no drain, buffer fills and refuses
		transmitter_on <= 3'h0;
		bits(12);
		check("oe", {line_out_pos_oe, line_out_neg_oe}, 6'h00);
		check("rail_ready", rail_ready, 3'h0);
		rd(STAT_OFS, 32'h700, 1'b0);
		stop_test();
	end
endmodule
